// ===== hdl/sdcap_pkg.sv
// Shared types and constants for the concurrent auto precharge bank logic
// How it works
// - Accept access to other bank during auto-precharge burst
// - Read-read interrupt ends old data after latency
// - Read-read interrupt precharges old bank at command
// - Write interrupts auto-precharge read at its registration
// - Read-write interrupt precharges old bank at command
// - Read interrupts write; data after read latency
// - Write-read interrupt precharges after write recovery
// - Read interrupt: last write data one clock before
// - Write interrupts auto-precharge write at its registration
// - Write-write interrupt precharges after write recovery
// - Write-write interrupt: last old data one clock before
// - Auto precharge closes row when burst completes
// - Precharged bank idles; needs activate before access
package sdcap_pkg;
    localparam int NUM_BANKS = 4;
    localparam int BANK_W = 2;
    localparam int COL_W = 10;
    localparam int DATA_W = 16;
    localparam int MAX_CAS_LAT = 3;
    localparam int CLK_PERIOD_NS = 25;
    localparam int WRITE_RECOVERY_NS = 30;
    localparam int ROW_PRECHARGE_NS = 18;
    localparam int WR_REC_RAW = (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_RECOVERY_CYC = (WR_REC_RAW < 1) ? 1 : WR_REC_RAW;
    localparam int RP_RAW = (ROW_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ROW_PRECHARGE_CYC = (RP_RAW < 1) ? 1 : RP_RAW;
    localparam int TIMER_W = 4;
    localparam logic [2:0] BL_CODE_1 = 3'h0;
    localparam logic [2:0] BL_CODE_2 = 3'h1;
    localparam logic [2:0] BL_CODE_4 = 3'h2;
    localparam logic [2:0] BL_CODE_8 = 3'h3;
    localparam logic [2:0] BL_CODE_FULL = 3'h7;
    localparam logic [COL_W-1:0] WRAP_1 = 10'h000;
    localparam logic [COL_W-1:0] WRAP_2 = 10'h001;
    localparam logic [COL_W-1:0] WRAP_4 = 10'h003;
    localparam logic [COL_W-1:0] WRAP_8 = 10'h007;
    localparam logic [COL_W-1:0] WRAP_FULL = 10'h3ff;

    typedef enum logic [2:0] {
        CMD_NOP,
        CMD_ACTIVE,
        CMD_READ,
        CMD_WRITE,
        CMD_PRECHARGE,
        CMD_BURST_STOP
    } sdcap_cmd_e;

    typedef enum logic [1:0] {
        BANK_IDLE,
        BANK_OPEN,
        BANK_RECOVER,
        BANK_PRECHARGE
    } sdcap_bank_e;

    typedef struct packed {
        sdcap_cmd_e cmd;
        logic [BANK_W-1:0] bank;
        logic [COL_W-1:0] col;
        logic auto_pre;
        logic all_banks;
    } sdcap_cmd_s;

    typedef struct packed {
        logic active;
        logic write;
        logic auto_pre;
        logic full;
        logic [BANK_W-1:0] bank;
        logic [COL_W-1:0] col;
        logic [COL_W-1:0] left;
    } sdcap_burst_s;

    typedef struct packed {
        logic [BANK_W-1:0] bank;
        logic [COL_W-1:0] col;
    } sdcap_loc_s;

    typedef struct packed {
        logic en;
        sdcap_loc_s loc;
        logic [DATA_W-1:0] data;
    } sdcap_wr_s;
endpackage

// ===== hdl/sdcap_bank.sv
// One bank's open, write recovery and precharge tracker
`timescale 1ns/1ps
module sdcap_bank #(
    parameter int REC_CYC = sdcap_pkg::WRITE_RECOVERY_CYC,
    parameter int RP_CYC = sdcap_pkg::ROW_PRECHARGE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Requests
    input wire logic activate,
    input wire logic pre_now,
    input wire logic pre_rec,
    // State
    output sdcap_pkg::sdcap_bank_e state,
    output logic pre_start
);
    import sdcap_pkg::*;

    localparam logic [TIMER_W-1:0] REC_LAST = TIMER_W'(REC_CYC - 1);
    localparam logic [TIMER_W-1:0] RP_LAST = TIMER_W'(RP_CYC - 1);

    sdcap_bank_e state_q, state_d;
    logic [TIMER_W-1:0] cnt_q, cnt_d;

    assign state = state_q;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        pre_start = 1'b0;
        unique case (state_q)
            BANK_IDLE: begin
                if (activate) begin
                    state_d = BANK_OPEN;
                end
            end
            BANK_OPEN: begin
                if (pre_now) begin
                    state_d = BANK_PRECHARGE;
                    cnt_d = RP_LAST;
                    pre_start = 1'b1;
                end else if (pre_rec) begin
                    state_d = BANK_RECOVER;
                    cnt_d = REC_LAST;
                end
            end
            BANK_RECOVER: begin
                if (cnt_q == '0) begin
                    state_d = BANK_PRECHARGE;
                    cnt_d = RP_LAST;
                    pre_start = 1'b1;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            BANK_PRECHARGE: begin
                if (cnt_q == '0) begin
                    state_d = BANK_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= BANK_IDLE;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end
endmodule

// ===== hdl/sdcap_rdpipe.sv
// Read latency pipeline carrying the location of each read element
`timescale 1ns/1ps
module sdcap_rdpipe #(
    parameter int MAX_LAT = sdcap_pkg::MAX_CAS_LAT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Issue side
    input wire logic in_valid,
    input sdcap_pkg::sdcap_loc_s in_loc,
    input wire logic [1:0] lat,
    // Output side
    output logic out_valid,
    output sdcap_pkg::sdcap_loc_s out_loc
);
    import sdcap_pkg::*;

    logic [MAX_LAT-1:0] vld_q, vld_d;
    sdcap_loc_s loc_q [MAX_LAT];
    sdcap_loc_s loc_d [MAX_LAT];
    logic [1:0] tap;

    always_comb begin
        vld_d = {vld_q[MAX_LAT-2:0], in_valid};
        loc_d[0] = in_loc;
        for (int i = 1; i < MAX_LAT; i++) begin
            loc_d[i] = loc_q[i-1];
        end
        // Zero latency is not a legal mode; treat it as one
        tap = (lat == 2'h0) ? 2'h0 : lat - 2'h1;
        out_valid = vld_q[tap];
        out_loc = loc_q[tap];
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            vld_q <= '0;
            for (int i = 0; i < MAX_LAT; i++) begin
                loc_q[i] <= '0;
            end
        end else begin
            vld_q <= vld_d;
            for (int i = 0; i < MAX_LAT; i++) begin
                loc_q[i] <= loc_d[i];
            end
        end
    end
endmodule

// ===== hdl/sdcap_top.sv
// Bank interaction, burst sequencing and concurrent auto precharge
`timescale 1ns/1ps
module sdcap_top (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Registered command
    input sdcap_pkg::sdcap_cmd_s cmd_i,
    // Write data and mask
    input wire logic [sdcap_pkg::DATA_W-1:0] wr_data_i,
    input wire logic wr_mask_i,
    // Mode settings
    input wire logic [1:0] cas_lat_i,
    input wire logic [2:0] burst_len_i,
    input wire logic wr_single_i,
    // Array write port
    output sdcap_pkg::sdcap_wr_s arr_wr_o,
    // Read data location
    output logic rd_valid_o,
    output sdcap_pkg::sdcap_loc_s rd_loc_o,
    output logic dq_oe_n_o,
    // Bank status
    output logic [sdcap_pkg::NUM_BANKS-1:0] bank_open_o,
    output logic [sdcap_pkg::NUM_BANKS-1:0] bank_idle_o,
    output logic [sdcap_pkg::NUM_BANKS-1:0] pre_start_o,
    output logic cmd_error_o
);
    import sdcap_pkg::*;

    sdcap_burst_s burst_q, burst_d;
    sdcap_wr_s wr_q, wr_d;
    logic err_q, err_d;

    sdcap_bank_e bank_state [NUM_BANKS];
    logic [NUM_BANKS-1:0] bank_open;
    logic [NUM_BANKS-1:0] bank_idle;
    logic [NUM_BANKS-1:0] act_vec;
    logic [NUM_BANKS-1:0] pre_cmd_vec;
    logic [NUM_BANKS-1:0] pre_now_vec;
    logic [NUM_BANKS-1:0] pre_rec_vec;
    logic [NUM_BANKS-1:0] pre_sel;
    logic [NUM_BANKS-1:0] ap_lock;
    logic [NUM_BANKS-1:0] cmd_onehot;
    logic [NUM_BANKS-1:0] old_onehot;

    logic is_rd;
    logic is_wr;
    logic is_acc;
    logic same_ap;
    logic acc_ok;
    logic acc_bad;
    logic stop_ok;
    logic stop_bad;
    logic pre_bad;
    logic act_bad;
    logic last_elem;
    logic burst_cut;
    logic old_ap_end;
    logic new_single;
    logic rd_issue;
    sdcap_loc_s rd_loc;
    logic [COL_W-1:0] wrap_mask;
    logic [COL_W-1:0] new_mask;
    logic new_full;

    // Column step that wraps inside the burst-aligned block
    function automatic logic [COL_W-1:0] col_next(
        input logic [COL_W-1:0] col,
        input logic [COL_W-1:0] mask
    );
        logic [COL_W-1:0] inc;
        inc = col + 1'b1;
        return (col & ~mask) | (inc & mask);
    endfunction

    // Burst length code to wrap mask; unknown codes run as full page
    always_comb begin
        unique case (burst_len_i)
            BL_CODE_1: wrap_mask = WRAP_1;
            BL_CODE_2: wrap_mask = WRAP_2;
            BL_CODE_4: wrap_mask = WRAP_4;
            BL_CODE_8: wrap_mask = WRAP_8;
            default: wrap_mask = WRAP_FULL;
        endcase
    end

    // Command classification
    always_comb begin
        is_rd = (cmd_i.cmd == CMD_READ);
        is_wr = (cmd_i.cmd == CMD_WRITE);
        is_acc = is_rd || is_wr;
        cmd_onehot = NUM_BANKS'(1) << cmd_i.bank;
        old_onehot = NUM_BANKS'(1) << burst_q.bank;
        ap_lock = (burst_q.active && burst_q.auto_pre) ? old_onehot : '0;
        same_ap = burst_q.active && burst_q.auto_pre && (burst_q.bank == cmd_i.bank);
        // Other banks may be accessed while an auto precharge burst runs
        acc_ok = is_acc && bank_open[cmd_i.bank] && !same_ap;
        acc_bad = is_acc && !acc_ok;
        act_vec = (cmd_i.cmd == CMD_ACTIVE) ? (cmd_onehot & bank_idle) : '0;
        act_bad = (cmd_i.cmd == CMD_ACTIVE) && !bank_idle[cmd_i.bank];
        pre_sel = cmd_i.all_banks ? '1 : cmd_onehot;
        // A bank under auto precharge ignores an explicit precharge
        pre_cmd_vec = (cmd_i.cmd == CMD_PRECHARGE) ? (pre_sel & bank_open & ~ap_lock) : '0;
        pre_bad = (cmd_i.cmd == CMD_PRECHARGE) && ((pre_sel & ap_lock) != '0);
        stop_ok = (cmd_i.cmd == CMD_BURST_STOP) && burst_q.active && !burst_q.auto_pre;
        stop_bad = (cmd_i.cmd == CMD_BURST_STOP) && burst_q.active && burst_q.auto_pre;
    end

    // Burst progress and its endings
    always_comb begin
        last_elem = burst_q.active && !burst_q.full && (burst_q.left == '0);
        burst_cut = acc_ok || stop_ok || (burst_q.active && pre_cmd_vec[burst_q.bank]);
        old_ap_end = burst_q.active && burst_q.auto_pre && (last_elem || acc_ok);
        new_mask = (is_wr && wr_single_i) ? WRAP_1 : wrap_mask;
        new_full = (new_mask == WRAP_FULL) && !(is_wr && wr_single_i);
        new_single = acc_ok && (new_mask == WRAP_1);
    end

    // Precharge requests to the bank trackers
    always_comb begin
        pre_now_vec = pre_cmd_vec;
        pre_rec_vec = '0;
        if (old_ap_end) begin
            if (burst_q.write) begin
                // Recovery counts from the interrupting command or last element
                pre_rec_vec = pre_rec_vec | old_onehot;
            end else begin
                pre_now_vec = pre_now_vec | old_onehot;
            end
        end
        if (new_single && cmd_i.auto_pre) begin
            if (is_wr) begin
                pre_rec_vec = pre_rec_vec | cmd_onehot;
            end else begin
                pre_now_vec = pre_now_vec | cmd_onehot;
            end
        end
    end

    // Write element of this cycle
    always_comb begin
        wr_d = '0;
        if (acc_ok && is_wr) begin
            // Data with a new write belongs to the new write
            wr_d.en = !wr_mask_i;
            wr_d.loc.bank = cmd_i.bank;
            wr_d.loc.col = cmd_i.col;
            wr_d.data = wr_data_i;
        end else if (burst_q.active && burst_q.write && !burst_cut) begin
            wr_d.en = !wr_mask_i;
            wr_d.loc.bank = burst_q.bank;
            wr_d.loc.col = burst_q.col;
            wr_d.data = wr_data_i;
        end
        // A read interrupt drops the data present with it
    end

    // Read element issued into the latency pipeline
    always_comb begin
        rd_issue = 1'b0;
        rd_loc = '0;
        if (acc_ok && is_rd) begin
            rd_issue = 1'b1;
            rd_loc.bank = cmd_i.bank;
            rd_loc.col = cmd_i.col;
        end else if (burst_q.active && !burst_q.write && !burst_cut) begin
            // A write interrupt stops issue at its own edge
            rd_issue = 1'b1;
            rd_loc.bank = burst_q.bank;
            rd_loc.col = burst_q.col;
        end
    end

    // Next burst state
    always_comb begin
        burst_d = burst_q;
        if (burst_q.active) begin
            burst_d.col = col_next(burst_q.col, wrap_mask);
            burst_d.left = burst_q.left - 1'b1;
            if (last_elem) begin
                burst_d.active = 1'b0;
            end
        end
        if (burst_cut) begin
            burst_d.active = 1'b0;
        end
        if (acc_ok) begin
            burst_d.active = (new_mask != WRAP_1);
            burst_d.write = is_wr;
            burst_d.auto_pre = cmd_i.auto_pre && !new_full;
            burst_d.full = new_full;
            burst_d.bank = cmd_i.bank;
            burst_d.col = col_next(cmd_i.col, new_mask);
            burst_d.left = new_mask - 1'b1;
        end
    end

    always_comb begin
        err_d = acc_bad || act_bad || pre_bad || stop_bad;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            burst_q <= '0;
            wr_q <= '0;
            err_q <= 1'b0;
        end else begin
            burst_q <= burst_d;
            wr_q <= wr_d;
            err_q <= err_d;
        end
    end

    // One independent tracker per bank
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        sdcap_bank #(
            .REC_CYC(WRITE_RECOVERY_CYC),
            .RP_CYC(ROW_PRECHARGE_CYC)
        ) u_bank (
            .clk(clk),
            .reset_n(reset_n),
            .activate(act_vec[b]),
            .pre_now(pre_now_vec[b]),
            .pre_rec(pre_rec_vec[b]),
            .state(bank_state[b]),
            .pre_start(pre_start_o[b])
        );
        assign bank_open[b] = (bank_state[b] == BANK_OPEN);
        assign bank_idle[b] = (bank_state[b] == BANK_IDLE);
    end

    sdcap_rdpipe #(
        .MAX_LAT(MAX_CAS_LAT)
    ) u_rdpipe (
        .clk(clk),
        .reset_n(reset_n),
        .in_valid(rd_issue),
        .in_loc(rd_loc),
        .lat(cas_lat_i),
        .out_valid(rd_valid_o),
        .out_loc(rd_loc_o)
    );

    // Bus contention on a read-to-write turn is left to the controller mask
    assign dq_oe_n_o = !rd_valid_o;
    assign arr_wr_o = wr_q;
    assign bank_open_o = bank_open;
    assign bank_idle_o = bank_idle;
    assign cmd_error_o = err_q;
endmodule

// ===== testbench/sdcap_top_properties.sv
// Port-level checks of bank state, read latency and precharge timing
`timescale 1ns/1ps
module sdcap_top_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Device inputs
    input sdcap_pkg::sdcap_cmd_s cmd_i,
    input wire logic [sdcap_pkg::DATA_W-1:0] wr_data_i,
    input wire logic wr_mask_i,
    input wire logic [1:0] cas_lat_i,
    input wire logic [2:0] burst_len_i,
    input wire logic wr_single_i,
    // Device outputs
    input sdcap_pkg::sdcap_wr_s arr_wr_o,
    input wire logic rd_valid_o,
    input sdcap_pkg::sdcap_loc_s rd_loc_o,
    input wire logic dq_oe_n_o,
    input wire logic [sdcap_pkg::NUM_BANKS-1:0] bank_open_o,
    input wire logic [sdcap_pkg::NUM_BANKS-1:0] bank_idle_o,
    input wire logic [sdcap_pkg::NUM_BANKS-1:0] pre_start_o,
    input wire logic cmd_error_o
);
    import sdcap_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic is_rd;
    logic is_wr;
    // A refused access may still be legal here, so each check built on is_rd or is_wr allows the error pulse
    assign is_rd = (cmd_i.cmd == CMD_READ) && bank_open_o[cmd_i.bank];
    assign is_wr = (cmd_i.cmd == CMD_WRITE) && bank_open_o[cmd_i.bank];
    a_active_opens: assert property (cmd_i.cmd == CMD_ACTIVE && bank_idle_o[cmd_i.bank]
        |=> bank_open_o[$past(cmd_i.bank)] && !cmd_error_o) else $error("activate did not open");
    a_closed_access_refused: assert property ((cmd_i.cmd inside {CMD_READ, CMD_WRITE})
        && bank_idle_o[cmd_i.bank] |=> cmd_error_o) else $error("idle bank access taken");
    a_busy_active_refused: assert property (cmd_i.cmd == CMD_ACTIVE
        && !bank_idle_o[cmd_i.bank] |=> cmd_error_o) else $error("busy bank activated");
    a_read_latency: assert property (is_rd && cas_lat_i == 2'd2 |=> cmd_error_o or
        ##1 (rd_valid_o && rd_loc_o == {$past(cmd_i.bank, 2), $past(cmd_i.col, 2)}))
        else $error("read element late or misplaced");
    a_write_element: assert property (is_wr && !wr_mask_i |=> cmd_error_o ||
        (arr_wr_o.en && arr_wr_o.loc == {$past(cmd_i.bank), $past(cmd_i.col)}
        && arr_wr_o.data == $past(wr_data_i))) else $error("write element lost");
    a_read_cuts_write: assert property (is_rd |=> cmd_error_o || !arr_wr_o.en)
        else $error("write went on under read");
    a_pre_closes_bank: assert property (pre_start_o[0] |=> !bank_open_o[0])
        else $error("bank open after precharge start");
    a_pre_then_idle: assert property (pre_start_o[0] |-> ##[1:4] bank_idle_o[0])
        else $error("bank not idle after precharge");
    a_oe_after_read: assert property (is_rd && cas_lat_i == 2'd2 |=> cmd_error_o or
        ##1 !dq_oe_n_o) else $error("output enable not low for read data");
    c_precharge: cover property (pre_start_o != 4'h0);
    c_read_then_write: cover property (rd_valid_o && cmd_i.cmd == CMD_WRITE);
    c_refused: cover property (cmd_error_o);
endmodule
bind sdcap_top sdcap_top_properties u_props (.clk(clk), .reset_n(reset_n), .cmd_i(cmd_i),
    .wr_data_i(wr_data_i), .wr_mask_i(wr_mask_i), .cas_lat_i(cas_lat_i),
    .burst_len_i(burst_len_i), .wr_single_i(wr_single_i), .arr_wr_o(arr_wr_o),
    .rd_valid_o(rd_valid_o), .rd_loc_o(rd_loc_o), .dq_oe_n_o(dq_oe_n_o),
    .bank_open_o(bank_open_o), .bank_idle_o(bank_idle_o), .pre_start_o(pre_start_o),
    .cmd_error_o(cmd_error_o));

// ===== testbench/sdcap_ctrl_model.sv
// Memory controller model presenting commands, write data and mask
`timescale 1ns/1ps
module sdcap_ctrl_model (
    // Clock
    input wire logic clk,
    // Towards the device
    output sdcap_pkg::sdcap_cmd_s cmd_o,
    output logic [sdcap_pkg::DATA_W-1:0] wr_data_o,
    output logic wr_mask_o
);
    import sdcap_pkg::*;
    initial begin
        cmd_o = '{CMD_NOP, 2'h0, 10'h000, 1'b0, 1'b0};
        wr_data_o = 16'h0000;
        wr_mask_o = 1'b0;
    end
    // Rows close by auto precharge or by an explicit precharge command issued here
    task automatic issue(input sdcap_cmd_e c, input logic [1:0] b, input logic [9:0] col,
            input logic ap, input logic [15:0] d, input logic m);
        @(posedge clk);
        cmd_o <= '{c, b, col, ap, 1'b0};
        wr_data_o <= d;
        wr_mask_o <= m;
    endtask
    // Mask ahead of a write that cuts a read, so the data bus never collides
    task automatic guard_write(input logic [1:0] b, input logic [9:0] col, input logic [15:0] d);
        repeat (3) issue(CMD_NOP, 2'h0, 10'h000, 1'b0, ~d, 1'b1);
        issue(CMD_WRITE, b, col, 1'b0, d, 1'b0);
    endtask
endmodule

// ===== testbench/sdcap_top_bench.sv
// Self-checking bench for the concurrent auto precharge bank logic
`timescale 1ns/1ps
module sdcap_top_bench;
    import sdcap_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    sdcap_cmd_s cmd;
    logic [DATA_W-1:0] wr_data;
    logic wr_mask;
    logic [1:0] cas_lat = 2'd2;
    logic [2:0] burst_len = BL_CODE_4;
    logic wr_single = 1'b0;
    sdcap_wr_s arr_wr;
    logic rd_valid;
    sdcap_loc_s rd_loc;
    logic dq_oe_n;
    logic [NUM_BANKS-1:0] bank_open;
    logic [NUM_BANKS-1:0] bank_idle;
    logic [NUM_BANKS-1:0] pre_start;
    logic cmd_error;
    int n_errors = 0;
    int checks = 0;
    integer seed = 32'hc467;
    logic [15:0] d;
    logic [15:0] da;
    logic [15:0] db;
    logic [9:0] c0;
    logic [1:0] rb;
    sdcap_ctrl_model ctrl (.clk(clk), .cmd_o(cmd), .wr_data_o(wr_data), .wr_mask_o(wr_mask));
    sdcap_top dut (.clk(clk), .reset_n(reset_n), .cmd_i(cmd), .wr_data_i(wr_data),
        .wr_mask_i(wr_mask), .cas_lat_i(cas_lat), .burst_len_i(burst_len),
        .wr_single_i(wr_single), .arr_wr_o(arr_wr), .rd_valid_o(rd_valid), .rd_loc_o(rd_loc),
        .dq_oe_n_o(dq_oe_n), .bank_open_o(bank_open), .bank_idle_o(bank_idle),
        .pre_start_o(pre_start), .cmd_error_o(cmd_error));
    initial begin
        forever #12.5 clk = ~clk;
    end
    function automatic sdcap_loc_s loc(input logic [1:0] b, input logic [9:0] c);
        return '{b, c};
    endfunction
    function automatic logic [3:0] one(input int b);
        return 4'h1 << b;
    endfunction
    task automatic check_v(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_loc(input string what, input sdcap_loc_s exp, input sdcap_loc_s got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Registered outputs seen here belong to the command of the previous step
    task automatic step(input sdcap_cmd_e c, input logic [1:0] b, input logic [9:0] col,
            input logic ap);
        d = 16'($random(seed));
        ctrl.issue(c, b, col, ap, d, 1'b0);
        @(negedge clk);
    endtask
    task automatic complete_run;
        if (n_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #(25 * 800);
        n_errors++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        check_v("bank_idle", 4'hf, bank_idle);
        check_v("dq_oe_n", 1'b1, dq_oe_n);
        for (int b = 0; b < 4; b++) step(CMD_ACTIVE, 2'(b), 10'h000, 1'b0);
        step(CMD_ACTIVE, 2'd0, 10'h000, 1'b0);
        check_v("bank_open", 4'hf, bank_open);
        step(CMD_NOP, 2'd0, 10'h000, 1'b0);
        check_v("cmd_error", 1'b1, cmd_error);
        c0 = 10'($random(seed)) & 10'h3fc;
        step(CMD_READ, 2'd0, c0, 1'b1);
        step(CMD_READ, 2'd1, 10'h000, 1'b0);
        check_v("pre_start", one(0), pre_start);
        step(CMD_NOP, 2'd0, 10'h000, 1'b0);
        check_loc("rd_loc", loc(2'd0, c0), rd_loc);
        step(CMD_NOP, 2'd0, 10'h000, 1'b0);
        check_loc("rd_loc", loc(2'd1, 10'h000), rd_loc);
        check_v("bank_idle", 4'h1, bank_idle);
        check_v("bank_open", 4'he, bank_open);
        step(CMD_READ, 2'd0, 10'h000, 1'b0);
        step(CMD_ACTIVE, 2'd0, 10'h000, 1'b0);
        check_v("cmd_error", 1'b1, cmd_error);
        @(posedge clk);
        burst_len <= BL_CODE_8;
        @(negedge clk);
        step(CMD_READ, 2'd2, 10'h000, 1'b1);
        da = 16'($random(seed));
        ctrl.guard_write(2'd3, 10'h008, da);
        @(negedge clk);
        check_v("pre_start", one(2), pre_start);
        step(CMD_NOP, 2'd0, 10'h000, 1'b0);
        check_v("arr_wr", {1'b1, loc(2'd3, 10'h008), da}, arr_wr);
        step(CMD_ACTIVE, 2'd2, 10'h000, 1'b0);
        step(CMD_WRITE, 2'd2, 10'h000, 1'b1);
        step(CMD_NOP, 2'd0, 10'h000, 1'b0);
        db = d;
        step(CMD_READ, 2'd3, 10'h010, 1'b0);
        check_v("arr_wr", {1'b1, loc(2'd2, 10'h001), db}, arr_wr);
        check_v("pre_start", 4'h0, pre_start);
        step(CMD_NOP, 2'd0, 10'h000, 1'b0);
        check_v("arr_wr_en", 1'b0, arr_wr.en);
        check_v("pre_start", 4'h0, pre_start);
        step(CMD_NOP, 2'd0, 10'h000, 1'b0);
        check_v("pre_start", one(2), pre_start);
        check_loc("rd_loc", loc(2'd3, 10'h010), rd_loc);
        step(CMD_NOP, 2'd0, 10'h000, 1'b0);
        step(CMD_ACTIVE, 2'd2, 10'h000, 1'b0);
        c0 = 10'($random(seed)) & 10'h3f8;
        step(CMD_WRITE, 2'd2, c0, 1'b1);
        da = d;
        step(CMD_WRITE, 2'd1, 10'h020, 1'b0);
        db = d;
        check_v("arr_wr", {1'b1, loc(2'd2, c0), da}, arr_wr);
        step(CMD_NOP, 2'd0, 10'h000, 1'b0);
        check_v("arr_wr", {1'b1, loc(2'd1, 10'h020), db}, arr_wr);
        check_v("pre_start", 4'h0, pre_start);
        step(CMD_NOP, 2'd0, 10'h000, 1'b0);
        check_v("pre_start", one(2), pre_start);
        check_v("bank_open", 4'hb, bank_open);
        for (int i = 0; i < 8; i++) begin
            rb = ({$random(seed)} % 2 == 0) ? 2'd0 : 2'd3;
            c0 = 10'($random(seed));
            step(CMD_READ, rb, c0, 1'b0);
            step(CMD_NOP, 2'd0, 10'h000, 1'b0);
            step(CMD_NOP, 2'd0, 10'h000, 1'b0);
            check_loc("rd_loc", loc(rb, c0), rd_loc);
        end
        // Longer latency and single writes
        @(posedge clk);
        cas_lat <= 2'd3;
        wr_single <= 1'b1;
        @(negedge clk);
        step(CMD_READ, 2'd3, 10'h040, 1'b0);
        repeat (3) step(CMD_NOP, 2'd0, 10'h000, 1'b0);
        check_loc("rd_loc", loc(2'd3, 10'h040), rd_loc);
        step(CMD_WRITE, 2'd3, 10'h030, 1'b1);
        da = d;
        step(CMD_NOP, 2'd0, 10'h000, 1'b0);
        check_v("arr_wr", {1'b1, loc(2'd3, 10'h030), da}, arr_wr);
        step(CMD_NOP, 2'd0, 10'h000, 1'b0);
        check_v("arr_wr_en", 1'b0, arr_wr.en);
        check_v("pre_start", one(3), pre_start);
        step(CMD_PRECHARGE, 2'd0, 10'h000, 1'b0);
        check_v("pre_start", one(0), pre_start);
        step(CMD_NOP, 2'd0, 10'h000, 1'b0);
        step(CMD_NOP, 2'd0, 10'h000, 1'b0);
        check_v("bank_idle", 4'hd, bank_idle);
        // Explicit precharge of a bank under auto precharge is refused
        step(CMD_READ, 2'd1, 10'h000, 1'b1);
        step(CMD_PRECHARGE, 2'd1, 10'h000, 1'b0);
        step(CMD_NOP, 2'd0, 10'h000, 1'b0);
        check_v("cmd_error", 1'b1, cmd_error);
        complete_run();
    end
endmodule
